/* File: hdl/lcg_top.sv */
// Function
// - Codes 0..7: pin A, instr clk, cell 3, RC clk, ref clk, reserved, TC2 aux, TC4 aux.
// - A set true-enable bit passes that source uninverted into its gate.
// - A set negated-enable bit passes that source inverted into its gate.
// - Gate 2 enables sit in low register bits 15..8, source 4 true down to source 1 negated.
// - Gate 1 enables sit in low register bits 7..0 in the same pair order.
// - Gate 4 enables sit in high register bits 15..8 in the same pair order.
// - Gate 3 enables sit in high register bits 7..0 in the same pair order.
// - Every source multiplexer offers both a true and a complemented output.
// - Each gate ORs its enabled inputs, giving the polarity level when none is enabled.
// - A set gate polarity bit inverts that gate's ORed result.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module lcg_top (
  input wire logic clk_i,                          // System clock, 25 MHz
  input wire logic rst_i,                          // Synchronous reset, high
  input wire logic wb_cyc_i,                       // Wishbone cycle
  input wire logic wb_stb_i,                       // Wishbone strobe
  input wire logic wb_we_i,                        // Write enable
  input wire logic [lcg_pkg::LCG_ADDR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i,                 // Byte lanes
  input wire logic [31:0] wb_dat_i,                // Write data
  output logic [31:0] wb_dat_o,                    // Read data
  output logic wb_ack_o,                           // Acknowledge
  input wire logic [7:0] src1_cand_i,              // Source 1 candidates, on-chip
  input wire logic [2:0] src_other_i,              // Sources 2..4, on-chip
  output logic [3:0] source1_select_o,             // Source 1 code (sel_o bit)
  output logic [3:0] gate_o                        // Gate outputs to logic core
);
  import lcg_pkg::*;

  // ========================================================================
  // Register file
  logic [15:0] input_source_select, next_input_source_select;
  logic [15:0] gate_select_low, next_gate_select_low;
  logic [15:0] gate_select_high, next_gate_select_high;
  logic [3:0] gate_polarity, next_gate_polarity;
  logic ack, next_ack;
  logic [31:0] rd_data, next_rd_data;
  logic req, wr;

  // Single-cycle classic answer; ack drops after one cycle
  assign req = wb_cyc_i && wb_stb_i && !ack;
  assign wr = req && wb_we_i;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) merge16[7:0] = d[7:0];
    if (sel[1]) merge16[15:8] = d[15:8];
  endfunction

  // Next register values and read mux
  always_comb begin
    next_input_source_select = input_source_select;
    next_gate_select_low = gate_select_low;
    next_gate_select_high = gate_select_high;
    next_gate_polarity = gate_polarity;
    next_ack = req;
    next_rd_data = 32'h0000_0000;
    if (wr) begin
      unique case (wb_adr_i)
        LCG_ADDR_SEL: next_input_source_select =
          merge16(input_source_select, wb_dat_i, wb_sel_i) & LCG_SEL_MASK;
        LCG_ADDR_GSL: next_gate_select_low = merge16(gate_select_low, wb_dat_i, wb_sel_i);
        LCG_ADDR_GSH: next_gate_select_high = merge16(gate_select_high, wb_dat_i, wb_sel_i);
        LCG_ADDR_POL: begin
          if (wb_sel_i[0]) next_gate_polarity = wb_dat_i[3:0];
        end
        default: ;  // Unmapped writes are acked and dropped
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        LCG_ADDR_SEL: next_rd_data = {16'h0000, input_source_select};
        LCG_ADDR_GSL: next_rd_data = {16'h0000, gate_select_low};
        LCG_ADDR_GSH: next_rd_data = {16'h0000, gate_select_high};
        // Polarity plus live gate state
        LCG_ADDR_POL: next_rd_data = {20'h00000, gate_o, 4'h0, gate_polarity};
        default: next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_source_select <= LCG_SEL_RST;
      gate_select_low <= LCG_GSL_RST;
      gate_select_high <= LCG_GSH_RST;
      gate_polarity <= LCG_POL_RST;
      ack <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      input_source_select <= next_input_source_select;
      gate_select_low <= next_gate_select_low;
      gate_select_high <= next_gate_select_high;
      gate_polarity <= next_gate_polarity;
      ack <= next_ack;
      rd_data <= next_rd_data;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;
  assign source1_select_o = input_source_select[LCG_SEL_FW-1:0];

  // ========================================================================
  // Data sources: true and negated rails
  logic [3:0] src_true, src_neg;

  lcg_src1_mux u_src1 (
    .sel_i(input_source_select[2:0]),
    .src_i(src1_cand_i),
    .true_o(src_true[0]),
    .neg_o(src_neg[0])
  );
  // Sources 2..4 are chosen upstream; only their rails are formed here
  assign src_true[3:1] = src_other_i;
  assign src_neg[3:1] = ~src_other_i;

  // ========================================================================
  // Input gates; field k of {high, low} belongs to gate k+1
  logic [31:0] gate_fields;
  assign gate_fields = {gate_select_high, gate_select_low};

  genvar g, s;
  generate
    for (g = 0; g < LCG_NGATE; g++) begin : g_gate
      logic [LCG_NSRC-1:0] hit;
      for (s = 0; s < LCG_NSRC; s++) begin : g_src
        // Pair for source s+1: true at odd bit, negated at even bit
        assign hit[s] = (gate_fields[g*LCG_GATE_FW + 2*s + 1] & src_true[s])
                      | (gate_fields[g*LCG_GATE_FW + 2*s] & src_neg[s]);
      end
      // Pure logic path so edits show without clock delay
      assign gate_o[g] = (|hit) ^ gate_polarity[g];
    end
  endgenerate

  // ========================================================================
  // Checks
  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_ack_follows;
    @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack after request");

  property p_none_pol;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_low[7:0] == 8'h00) |-> (gate_o[0] == gate_polarity[0]);
  endproperty
  a_none_pol: assert property (p_none_pol) else $error("empty gate 1 wrong");

  property p_g1_src1_true;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_low[7:0] == 8'h02 && !gate_polarity[0]) |-> (gate_o[0] == src_true[0]);
  endproperty
  a_g1_src1_true: assert property (p_g1_src1_true) else $error("gate 1 true path");

  property p_g2_src4_neg;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_low[15:8] == 8'h40 && !gate_polarity[1]) |-> (gate_o[1] == ~src_other_i[2]);
  endproperty
  a_g2_src4_neg: assert property (p_g2_src4_neg) else $error("gate 2 neg path");

  property p_g3_pol;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_high[7:0] == 8'h20 && gate_polarity[2]) |-> (gate_o[2] == ~src_other_i[1]);
  endproperty
  a_g3_pol: assert property (p_g3_pol) else $error("gate 3 polarity");

  property p_g4_both;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_high[15:8] == 8'h0c && !gate_polarity[3]) |-> gate_o[3];
  endproperty
  a_g4_both: assert property (p_g4_both) else $error("gate 4 true or neg");

  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
      (input_source_select[2:0] == LCG_S1_RSVD) |-> !src_true[0];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved source not low");

  property p_write_lands;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == LCG_ADDR_GSL && wb_sel_i[1:0] == 2'b11)
        |=> (gate_select_low == $past(wb_dat_i[15:0]));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("low gate write lost");

  // Every non-reserved code must route its own candidate, not a neighbour
  property p_src1_pick;
    @(posedge clk_i) disable iff (rst_i)
      (input_source_select[2:0] != LCG_S1_RSVD)
        |-> (src_true[0] == src1_cand_i[input_source_select[2:0]]);
  endproperty
  a_src1_pick: assert property (p_src1_pick) else $error("source 1 wrong pick");

  // One enable per field; catches a swapped gate field or pair order
  property p_g2_src1_true;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_low[15:8] == 8'h02 && !gate_polarity[1]) |-> (gate_o[1] == src_true[0]);
  endproperty
  a_g2_src1_true: assert property (p_g2_src1_true) else $error("gate 2 field");

  property p_g1_src2_true;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_low[7:0] == 8'h08 && !gate_polarity[0]) |-> (gate_o[0] == src_other_i[0]);
  endproperty
  a_g1_src2_true: assert property (p_g1_src2_true) else $error("gate 1 field");

  property p_g3_src4_true;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_high[7:0] == 8'h80 && !gate_polarity[2]) |-> (gate_o[2] == src_other_i[2]);
  endproperty
  a_g3_src4_true: assert property (p_g3_src4_true) else $error("gate 3 field");

  property p_g4_src1_neg;
    @(posedge clk_i) disable iff (rst_i)
      (gate_select_high[15:8] == 8'h01 && !gate_polarity[3]) |-> (gate_o[3] == !src_true[0]);
  endproperty
  a_g4_src1_neg: assert property (p_g4_src1_neg) else $error("gate 4 neg rail");

  c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr);
  c_rsvd: cover property (@(posedge clk_i) disable iff (rst_i)
    input_source_select[2:0] == LCG_S1_RSVD);
  c_read: cover property (@(posedge clk_i) disable iff (rst_i) req && !wb_we_i);
  c_gate_hi: cover property (@(posedge clk_i) disable iff (rst_i) gate_o == 4'hf);
endmodule // lcg_top
`default_nettype wire

/* File: hdl/lcg_pkg.sv */
`default_nettype none
// ==========================================================================
// Register map and field layout
package lcg_pkg;
  // Register byte addresses (one aligned word each)
  localparam logic [3:0] LCG_ADDR_SEL = 4'h0;
  localparam logic [3:0] LCG_ADDR_GSL = 4'h4;
  localparam logic [3:0] LCG_ADDR_GSH = 4'h8;
  localparam logic [3:0] LCG_ADDR_POL = 4'hc;
  localparam int LCG_ADDR_W = 4;
  // Reset values
  localparam logic [15:0] LCG_SEL_RST = 16'h0000;
  localparam logic [15:0] LCG_GSL_RST = 16'h0000;
  localparam logic [15:0] LCG_GSH_RST = 16'h0000;
  localparam logic [3:0] LCG_POL_RST = 4'h0;
  // Field layout
  localparam int LCG_NSRC = 4;
  localparam int LCG_NGATE = 4;
  localparam int LCG_SEL_FW = 4;
  localparam int LCG_GATE_FW = 8;
  localparam logic [15:0] LCG_SEL_MASK = 16'h7777;
  // Source select 1 codes
  localparam logic [2:0] LCG_S1_PIN_A = 3'h0;
  localparam logic [2:0] LCG_S1_INSTR_CLK = 3'h1;
  localparam logic [2:0] LCG_S1_CELL3 = 3'h2;
  localparam logic [2:0] LCG_S1_RC_CLK = 3'h3;
  localparam logic [2:0] LCG_S1_REF_CLK = 3'h4;
  localparam logic [2:0] LCG_S1_RSVD = 3'h5;
  localparam logic [2:0] LCG_S1_TC2_AUX = 3'h6;
  localparam logic [2:0] LCG_S1_TC4_AUX = 3'h7;
endpackage : lcg_pkg
`default_nettype wire

/* File: hdl/lcg_src1_mux.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Data-source multiplexer 1
module lcg_src1_mux (
  input wire logic [2:0] sel_i,        // Source select code
  input wire logic [7:0] src_i,        // Candidate signals, index = code
  output logic true_o,                 // Selected signal
  output logic neg_o                   // Its complement
);
  import lcg_pkg::*;
  // Decode; reserved code yields constant low
  always_comb begin
    unique case (sel_i)
      LCG_S1_PIN_A: true_o = src_i[LCG_S1_PIN_A];
      LCG_S1_INSTR_CLK: true_o = src_i[LCG_S1_INSTR_CLK];
      LCG_S1_CELL3: true_o = src_i[LCG_S1_CELL3];
      LCG_S1_RC_CLK: true_o = src_i[LCG_S1_RC_CLK];
      LCG_S1_REF_CLK: true_o = src_i[LCG_S1_REF_CLK];
      LCG_S1_RSVD: true_o = 1'b0;
      LCG_S1_TC2_AUX: true_o = src_i[LCG_S1_TC2_AUX];
      LCG_S1_TC4_AUX: true_o = src_i[LCG_S1_TC4_AUX];
    endcase
  end
  assign neg_o = ~true_o;
endmodule // lcg_src1_mux
`default_nettype wire

/* File: bench/lcg_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// On-chip signal sources feeding the selector
module lcg_src_model (
  input wire logic [3:0] level_i,  // Wanted levels of sources 1..4
  input wire logic [2:0] code_i,   // Code the bench selected
  output logic [7:0] cand_o,       // Source 1 candidates
  output logic [2:0] other_o       // Sources 2..4
);
  // Unpicked candidates carry the opposite level, so a wrong pick shows
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cand_o[i] = (i == int'(code_i)) ? level_i[0] : ~level_i[0];
    end
    other_o = level_i[3:1];
  end
endmodule // lcg_src_model
`default_nettype wire

/* File: bench/logic_cell_gate_input_select_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module logic_cell_gate_input_select_tb_top;
  import lcg_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [3:0] adr, bsel, lvl, gate_o, s1o;
  logic [2:0] code, oth;
  logic [7:0] cand;
  logic [31:0] wdat, rdat, q, en;
  logic [3:0] pol, ge;
  int fails, n_compared;
  lcg_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .src1_cand_i(cand), .src_other_i(oth),
    .source1_select_o(s1o), .gate_o(gate_o));
  lcg_src_model i_src (.level_i(lvl), .code_i(code), .cand_o(cand), .other_o(oth));
  // ==========================================================================
  // Helpers
  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; the answer is taken on the ack edge only
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    bsel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Only a missing answer is a timeout, not one that came on the last try
    if (ack !== 1'b1) begin
      fails++;
      $display("[FAIL] wb_ack_o expected 1 seen %b", ack);
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("read data", e, q);
  endtask
  // Model of the gates from the register layout
  function automatic logic [3:0] exp_g(logic [31:0] e, logic [3:0] p, logic [3:0] s);
    logic [3:0] g;
    g = 4'h0;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        g[k] |= (e[8*k+2*i+1] & s[i]) | (e[8*k+2*i] & ~s[i]);
      end
    end
    return g ^ p;
  endfunction
  // ==========================================================================
  // Clock and sequence
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    bsel = 4'h0;
    wdat = 32'h0;
    lvl = 4'h0;
    code = 3'h0;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(LCG_ADDR_SEL, 32'(LCG_SEL_RST));
    rd(LCG_ADDR_GSL, 32'(LCG_GSL_RST));
    rd(LCG_ADDR_GSH, 32'(LCG_GSH_RST));
    rd(LCG_ADDR_POL, 32'(LCG_POL_RST));
    chk("gate_o", 32'h0, 32'(gate_o));
    wb(1'b1, LCG_ADDR_SEL, 32'hffff);
    rd(LCG_ADDR_SEL, 32'(LCG_SEL_MASK));
    wb(1'b1, 4'h2, 32'hffff);
    rd(4'h2, 32'h0);
    // Each source 1 code, gate 1 taking source 1 true
    wb(1'b1, LCG_ADDR_GSL, 32'h2);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, LCG_ADDR_SEL, 32'(c));
      code <= 3'(c);
      lvl <= 4'h1;
      @(posedge clk_i);
      #1;
      chk("source 1 gate", (3'(c) == LCG_S1_RSVD) ? 32'h0 : 32'h1, 32'(gate_o[0]));
      chk("source1_select_o", 32'(c), 32'(s1o));
    end
    wb(1'b1, LCG_ADDR_SEL, 32'h0);
    code <= 3'h0;
    // Each enable bit alone, every level pattern, both polarities
    for (int p = 0; p < 2; p++) begin
      pol = p ? 4'hf : 4'h0;
      wb(1'b1, LCG_ADDR_POL, 32'(pol));
      for (int b = -1; b < 32; b++) begin
        en = (b < 0) ? 32'h0 : (32'h1 << b);
        wb(1'b1, LCG_ADDR_GSL, {16'h0, en[15:0]});
        wb(1'b1, LCG_ADDR_GSH, {16'h0, en[31:16]});
        // Looked at within the cycle the levels change: a clocked gate fails
        for (int v = 0; v < 16; v++) begin
          @(posedge clk_i);
          lvl <= 4'(v);
          #1;
          ge = exp_g(en, pol, 4'(v));
          chk("gate_o", 32'(ge), 32'(gate_o));
        end
        rd(LCG_ADDR_POL, {20'h0, exp_g(en, pol, 4'hf), 4'h0, pol});
      end
    end
    // Several enables per gate at once, true and negated rails ORed
    pol = 4'h0;
    wb(1'b1, LCG_ADDR_POL, 32'(pol));
    en = 32'h0c42_3a81;
    wb(1'b1, LCG_ADDR_GSL, {16'h0, en[15:0]});
    wb(1'b1, LCG_ADDR_GSH, {16'h0, en[31:16]});
    for (int v = 0; v < 16; v++) begin
      @(posedge clk_i);
      lvl <= 4'(v);
      #1;
      ge = exp_g(en, pol, 4'(v));
      chk("gate_o multi", 32'(ge), 32'(gate_o));
    end
    // Reset in mid-run clears the written enables again
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(LCG_ADDR_GSL, 32'(LCG_GSL_RST));
    rd(LCG_ADDR_GSH, 32'(LCG_GSH_RST));
    chk("gate_o after reset", 32'h0, 32'(gate_o));
    tally_and_finish();
  end
endmodule // logic_cell_gate_input_select_tb_top
`default_nettype wire
